/* File: src/ccr_pkg.sv */
package ccr_pkg;
    // Register word and link widths
    localparam int CCR_DW = 16;
    localparam int CCR_AW = 4;
    localparam int CCR_FRAME_BITS = 24;

    // Device register addresses
    localparam logic [3:0] CCR_ADDR_CONFIG = 4'h0;
    localparam logic [3:0] CCR_ADDR_RSVD1  = 4'h1;
    localparam logic [3:0] CCR_ADDR_OFFSET = 4'h2;
    localparam logic [3:0] CCR_ADDR_RANGE  = 4'h3;

    // Power-on values
    localparam logic [15:0] CCR_CONFIG_RST = 16'h2000;
    localparam logic [15:0] CCR_RSVD1_RST  = 16'h2A0E;
    localparam logic [15:0] CCR_OFFSET_RST = 16'h0000;
    localparam logic [15:0] CCR_RANGE_RST  = 16'h4000;
    localparam logic [15:0] CCR_ZERO       = 16'h0000;

    // Main configuration word fields
    localparam int CCR_BIT_CAL     = 15;
    localparam int CCR_BIT_PHASE   = 14;
    localparam int CCR_BIT_SWING   = 13;
    localparam int CCR_BIT_PATTERN = 12;
    localparam int CCR_BIT_IPD     = 11;
    localparam int CCR_BIT_QPD     = 10;
    localparam int CCR_BIT_LOWRATE = 8;
    localparam int CCR_BIT_DES     = 7;
    localparam int CCR_BIT_INSEL   = 6;
    localparam int CCR_BIT_SHORT   = 5;
    localparam int CCR_BIT_TWOS    = 4;
    localparam int CCR_BIT_STAMP   = 3;
    localparam logic [2:0] CCR_SHORT_MODE = 3'h5;

    // Trim word fields
    localparam int CCR_BIT_OFS_SIGN = 12;
    localparam int CCR_OFS_MAG_W    = 12;
    localparam int CCR_RANGE_W      = 15;
    localparam int CCR_MONO_BITS    = 9;

    // Serial frame layout: read flag, three zeros, address, data
    localparam int CCR_FRAME_RW   = 23;
    localparam int CCR_FRAME_ADDR = 16;
    localparam logic [4:0] CCR_HDR_LAST   = 5'h07;
    localparam logic [4:0] CCR_FRAME_LAST = 5'h17;
    localparam logic [4:0] CCR_CNT_ZERO   = 5'h00;
    localparam logic [4:0] CCR_CNT_ONE    = 5'h01;

    // Host command port registers
    localparam logic [1:0] CCR_H_TXDATA = 2'h0;
    localparam logic [1:0] CCR_H_CMD    = 2'h1;
    localparam logic [1:0] CCR_H_STATUS = 2'h2;
    localparam logic [1:0] CCR_H_RXDATA = 2'h3;
    localparam int CCR_CMD_RW = 4;

    typedef enum logic [1:0] {
        CCR_IDLE  = 2'h0,
        CCR_SHIFT = 2'h1,
        CCR_GAP   = 2'h3
    } ccr_host_state_t;
endpackage : ccr_pkg

/* File: src/ccr_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Serial control link: host makes select and clock, device answers on miso
interface ccr_link_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso;
    modport host   (output cs_n, output sclk, output mosi, input miso);
    modport device (input cs_n, input sclk, input mosi, output miso);
endinterface : ccr_link_if
`default_nettype wire

/* File: src/ccr_device.sv */
`timescale 1ns/1ps
`default_nettype none
module ccr_device
    import ccr_pkg::*;
(
    input  wire logic                     mclk,
    input  wire logic                     reset_n,
    ccr_link_if.device                    link,
    input  wire logic                     extended_control_mode,
    input  wire logic                     cal_pin,
    input  wire logic                     i_pd_pin,
    input  wire logic                     q_pd_pin,
    input  wire logic                     demux_enable,
    input  wire logic [CCR_DW-1:0]        pin_config,
    output logic                          cal_start,
    output logic                          clock_phase_select,
    output logic                          output_swing_high,
    output logic                          fixed_pattern_mode,
    output logic                          i_power_down,
    output logic                          q_power_down,
    output logic                          low_rate_select,
    output logic                          dual_edge_mode,
    output logic                          interleave_input_sel,
    output logic                          both_input_short,
    output logic                          twos_comp_output,
    output logic                          stamp_enable,
    output logic                          offset_sign,
    output logic [CCR_OFS_MAG_W-1:0]      offset_magnitude,
    output logic [CCR_RANGE_W-1:0]        range_magnitude,
    output logic [CCR_MONO_BITS-1:0]      range_coarse
);
    // Link state
    logic                      sclk_q, next_sclk_q;
    logic [4:0]                bit_count, next_bit_count;
    logic [CCR_FRAME_BITS-1:0] shift_in, next_shift_in;
    logic [CCR_DW-1:0]         shift_out, next_shift_out;
    logic                      sdo, next_sdo;
    // Register bank
    logic [CCR_DW-1:0] config_reg, next_config_reg;
    logic [CCR_DW-1:0] rsvd1_reg, next_rsvd1_reg;
    logic [CCR_DW-1:0] offset_reg, next_offset_reg;
    logic [CCR_DW-1:0] range_reg, next_range_reg;
    // Calibration arming
    logic cal_armed, next_cal_armed;
    logic next_cal_start;
    // Effective outputs
    logic [CCR_DW-1:0] cfg, ofs, rng;
    logic next_phase, next_swing, next_pattern, next_ipd, next_qpd, next_lowrate;
    logic next_des, next_insel, next_short, next_twos, next_stamp, next_osign;
    logic [CCR_OFS_MAG_W-1:0] next_omag;
    logic [CCR_RANGE_W-1:0]   next_rmag;
    logic sclk_rise, sclk_fall, cal_req;
    logic [CCR_FRAME_BITS-1:0] frame;

    // Read decode; unmapped addresses read as zero
    function automatic logic [CCR_DW-1:0] ccr_read(input logic [CCR_AW-1:0] a);
        case (a)
            CCR_ADDR_CONFIG: ccr_read = config_reg;
            CCR_ADDR_RSVD1:  ccr_read = rsvd1_reg;
            CCR_ADDR_OFFSET: ccr_read = offset_reg;
            CCR_ADDR_RANGE:  ccr_read = range_reg;
            default:         ccr_read = CCR_ZERO;
        endcase
    endfunction : ccr_read

    // Serial slave: sample on rising sclk, drive miso after falling sclk
    always_comb begin
        sclk_rise       = link.sclk & ~sclk_q & ~link.cs_n;
        sclk_fall       = ~link.sclk & sclk_q & ~link.cs_n;
        frame           = {shift_in[CCR_FRAME_BITS-2:0], link.mosi};
        next_sclk_q     = link.sclk;
        next_bit_count  = bit_count;
        next_shift_in   = shift_in;
        next_shift_out  = shift_out;
        next_sdo        = sdo;
        next_config_reg = config_reg;
        next_rsvd1_reg  = rsvd1_reg;
        next_offset_reg = offset_reg;
        next_range_reg  = range_reg;
        if (link.cs_n) begin
            next_bit_count = CCR_CNT_ZERO;
            next_shift_out = CCR_ZERO;
            next_sdo       = 1'b0;
        end else if (sclk_rise) begin
            next_shift_in  = frame;
            next_bit_count = bit_count + CCR_CNT_ONE;
            // Read word captured once the header is in
            if (bit_count == CCR_HDR_LAST) begin
                next_shift_out = frame[CCR_FRAME_RW - CCR_DW] ? ccr_read(frame[CCR_AW-1:0]) : CCR_ZERO;
            end
            // Whole word committed on the last bit; reserved bits kept as written
            if (bit_count == CCR_FRAME_LAST && !frame[CCR_FRAME_RW]) begin
                case (frame[CCR_FRAME_ADDR +: CCR_AW])
                    CCR_ADDR_CONFIG: next_config_reg = frame[CCR_DW-1:0];
                    CCR_ADDR_RSVD1:  next_rsvd1_reg  = frame[CCR_DW-1:0];
                    CCR_ADDR_OFFSET: next_offset_reg = frame[CCR_DW-1:0];
                    CCR_ADDR_RANGE:  next_range_reg  = frame[CCR_DW-1:0];
                    default:         next_config_reg = config_reg;
                endcase
            end
        end else if (sclk_fall && bit_count > CCR_HDR_LAST) begin
            next_sdo       = shift_out[CCR_DW-1];
            next_shift_out = {shift_out[CCR_DW-2:0], 1'b0};
        end
    end

    // Pin word takes over the config when not in extended control mode; trims use power-on values
    always_comb begin
        cfg = extended_control_mode ? config_reg : pin_config;
        ofs = extended_control_mode ? offset_reg : CCR_OFFSET_RST;
        rng = extended_control_mode ? range_reg  : CCR_RANGE_RST;
        // Bit and pin share one request; a new start needs both low first
        cal_req        = (extended_control_mode & config_reg[CCR_BIT_CAL]) | cal_pin;
        next_cal_start = cal_req & cal_armed;
        next_cal_armed = ~cal_req | (cal_armed & ~next_cal_start);
        next_phase   = cfg[CCR_BIT_PHASE] & demux_enable;
        next_swing   = cfg[CCR_BIT_SWING];
        next_pattern = cfg[CCR_BIT_PATTERN];
        next_ipd     = cfg[CCR_BIT_IPD] | i_pd_pin;
        next_qpd     = cfg[CCR_BIT_QPD] | q_pd_pin;
        next_lowrate = cfg[CCR_BIT_LOWRATE];
        next_des     = cfg[CCR_BIT_DES];
        next_insel   = cfg[CCR_BIT_DES] & cfg[CCR_BIT_INSEL];
        next_short   = cfg[CCR_BIT_DES -: 3] == CCR_SHORT_MODE;
        next_twos    = cfg[CCR_BIT_TWOS];
        next_stamp   = cfg[CCR_BIT_STAMP];
        next_osign   = ofs[CCR_BIT_OFS_SIGN];
        next_omag    = ofs[CCR_OFS_MAG_W-1:0];
        next_rmag    = rng[CCR_RANGE_W-1:0];
    end

    // Registers; the analog side may only rely on the coarse range bits
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_q               <= 1'b0;
            bit_count            <= CCR_CNT_ZERO;
            shift_in             <= '0;
            shift_out            <= CCR_ZERO;
            sdo                  <= 1'b0;
            config_reg           <= CCR_CONFIG_RST;
            rsvd1_reg            <= CCR_RSVD1_RST;
            offset_reg           <= CCR_OFFSET_RST;
            range_reg            <= CCR_RANGE_RST;
            cal_armed            <= 1'b0;
            cal_start            <= 1'b0;
            clock_phase_select   <= 1'b0;
            output_swing_high    <= 1'b0;
            fixed_pattern_mode   <= 1'b0;
            i_power_down         <= 1'b0;
            q_power_down         <= 1'b0;
            low_rate_select      <= 1'b0;
            dual_edge_mode       <= 1'b0;
            interleave_input_sel <= 1'b0;
            both_input_short     <= 1'b0;
            twos_comp_output     <= 1'b0;
            stamp_enable         <= 1'b0;
            offset_sign          <= 1'b0;
            offset_magnitude     <= '0;
            range_magnitude      <= '0;
            range_coarse         <= '0;
        end else begin
            sclk_q               <= next_sclk_q;
            bit_count            <= next_bit_count;
            shift_in             <= next_shift_in;
            shift_out            <= next_shift_out;
            sdo                  <= next_sdo;
            config_reg           <= next_config_reg;
            rsvd1_reg            <= next_rsvd1_reg;
            offset_reg           <= next_offset_reg;
            range_reg            <= next_range_reg;
            cal_armed            <= next_cal_armed;
            cal_start            <= next_cal_start;
            clock_phase_select   <= next_phase;
            output_swing_high    <= next_swing;
            fixed_pattern_mode   <= next_pattern;
            i_power_down         <= next_ipd;
            q_power_down         <= next_qpd;
            low_rate_select      <= next_lowrate;
            dual_edge_mode       <= next_des;
            interleave_input_sel <= next_insel;
            both_input_short     <= next_short;
            twos_comp_output     <= next_twos;
            stamp_enable         <= next_stamp;
            offset_sign          <= next_osign;
            offset_magnitude     <= next_omag;
            range_magnitude      <= next_rmag;
            range_coarse         <= next_rmag[CCR_RANGE_W-1 -: CCR_MONO_BITS];
        end
    end

    assign link.miso = sdo;
endmodule : ccr_device
`default_nettype wire

/* File: src/ccr_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Host end: software loads data and a command; one serial frame follows
module ccr_host
    import ccr_pkg::*;
#(
    parameter int HALF_CYCLES = 4
) (
    input  wire logic              mclk,
    input  wire logic              reset_n,
    ccr_link_if.host               link,
    input  wire logic [1:0]        addr,
    input  wire logic [CCR_DW-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic [CCR_DW-1:0]      rdata
);
    localparam logic [7:0] HALF_LAST = 8'(HALF_CYCLES - 1);

    ccr_host_state_t           state, next_state;
    logic [7:0]                div, next_div;
    logic [4:0]                bit_count, next_bit_count;
    logic [CCR_FRAME_BITS-1:0] shift, next_shift;
    logic [CCR_DW-1:0]         tx_data, next_tx_data;
    logic [CCR_DW-1:0]         rx_shift, next_rx_shift;
    logic [CCR_DW-1:0]         rx_data, next_rx_data;
    logic                      is_read, next_is_read;
    logic                      sclk, next_sclk;
    logic                      cs_n, next_cs_n;
    logic [CCR_DW-1:0]         next_rdata;
    logic                      half_done;

    // Frame sequencer; the host must also write reserved bits at power-on values
    always_comb begin
        half_done      = div == HALF_LAST;
        next_state     = state;
        next_div       = div;
        next_bit_count = bit_count;
        next_shift     = shift;
        next_tx_data   = tx_data;
        next_rx_shift  = rx_shift;
        next_rx_data   = rx_data;
        next_is_read   = is_read;
        next_sclk      = sclk;
        next_cs_n      = cs_n;
        case (state)
            CCR_IDLE: begin
                // Writes while a frame runs are dropped, so the frame stays intact
                if (wr && addr == CCR_H_TXDATA) begin
                    next_tx_data = wdata;
                end
                if (wr && addr == CCR_H_CMD) begin
                    next_shift     = {wdata[CCR_CMD_RW], 3'h0, wdata[CCR_AW-1:0], tx_data};
                    next_is_read   = wdata[CCR_CMD_RW];
                    next_state     = CCR_SHIFT;
                    next_cs_n      = 1'b0;
                    next_div       = 8'h00;
                    next_bit_count = CCR_CNT_ZERO;
                end
            end
            CCR_SHIFT: begin
                next_div = div + 8'h01;
                if (half_done) begin
                    next_div  = 8'h00;
                    next_sclk = ~sclk;
                    // End of the high half: sample miso, then move to the next bit
                    if (sclk) begin
                        next_rx_shift  = {rx_shift[CCR_DW-2:0], link.miso};
                        next_shift     = {shift[CCR_FRAME_BITS-2:0], 1'b0};
                        next_bit_count = bit_count + CCR_CNT_ONE;
                        if (bit_count == CCR_FRAME_LAST) begin
                            next_state = CCR_GAP;
                            next_cs_n  = 1'b1;
                            if (is_read) begin
                                next_rx_data = {rx_shift[CCR_DW-2:0], link.miso};
                            end
                        end
                    end
                end
            end
            CCR_GAP: begin
                // Deselect time between frames
                next_div = div + 8'h01;
                if (half_done) begin
                    next_div   = 8'h00;
                    next_state = CCR_IDLE;
                end
            end
            default: begin
                next_state = CCR_IDLE;
                next_cs_n  = 1'b1;
                next_sclk  = 1'b0;
            end
        endcase
        // Read data stands only in the cycle after the strobe
        next_rdata = CCR_ZERO;
        if (rd) begin
            case (addr)
                CCR_H_TXDATA: next_rdata = tx_data;
                CCR_H_STATUS: next_rdata = {15'h0000, state != CCR_IDLE};
                CCR_H_RXDATA: next_rdata = rx_data;
                default:      next_rdata = CCR_ZERO;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state     <= CCR_IDLE;
            div       <= 8'h00;
            bit_count <= CCR_CNT_ZERO;
            shift     <= '0;
            tx_data   <= CCR_ZERO;
            rx_shift  <= CCR_ZERO;
            rx_data   <= CCR_ZERO;
            is_read   <= 1'b0;
            sclk      <= 1'b0;
            cs_n      <= 1'b1;
            rdata     <= CCR_ZERO;
        end else begin
            state     <= next_state;
            div       <= next_div;
            bit_count <= next_bit_count;
            shift     <= next_shift;
            tx_data   <= next_tx_data;
            rx_shift  <= next_rx_shift;
            rx_data   <= next_rx_data;
            is_read   <= next_is_read;
            sclk      <= next_sclk;
            cs_n      <= next_cs_n;
            rdata     <= next_rdata;
        end
    end

    assign link.cs_n = cs_n;
    assign link.sclk = sclk;
    assign link.mosi = shift[CCR_FRAME_BITS-1];
endmodule : ccr_host
`default_nettype wire

/* File: dv/ccr_link_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the serial link and a few decoded device outputs
module ccr_link_asserts #(
    parameter int HALF_CYCLES = 4
) (
    input wire logic        mclk,
    input wire logic        reset_n,
    input wire logic        cs_n,
    input wire logic        sclk,
    input wire logic        mosi,
    input wire logic        miso,
    input wire logic        demux_enable,
    input wire logic        i_pd_pin,
    input wire logic        cal_start,
    input wire logic        clock_phase_select,
    input wire logic        i_power_down,
    input wire logic        dual_edge_mode,
    input wire logic        interleave_input_sel,
    input wire logic        both_input_short,
    input wire logic [14:0] range_magnitude,
    input wire logic [8:0]  range_coarse
);
    logic [5:0] nrise;
    logic       sclk_d;

    // Rises seen in one select window; a short frame would be dropped by the device
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            nrise  <= 6'h00;
            sclk_d <= 1'b0;
        end else begin
            sclk_d <= sclk;
            nrise  <= cs_n ? 6'h00 : nrise + {5'h00, sclk & ~sclk_d};
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_quiet;
        cs_n && !sclk && !miso;
    endsequence
    sequence s_high_half;
        $past(sclk, HALF_CYCLES) && !$past(sclk, HALF_CYCLES + 1);
    endsequence

    property p_idle;
        cs_n && $past(cs_n) |-> s_quiet;
    endproperty
    a_idle: assert property (p_idle) else $error("link not quiet while deselected");
    property p_high;
        $fell(sclk) |-> s_high_half;
    endproperty
    a_high: assert property (p_high) else $error("serial clock high half has wrong length");
    property p_frame;
        $rose(cs_n) |-> nrise == 6'h18;
    endproperty
    a_frame: assert property (p_frame) else $error("frame is not 24 serial clocks");
    property p_mosi;
        !cs_n && sclk |-> $stable(mosi);
    endproperty
    a_mosi: assert property (p_mosi) else $error("host data moved while clock high");
    property p_cal;
        cal_start |=> !cal_start;
    endproperty
    a_cal: assert property (p_cal) else $error("calibration start longer than one cycle");
    property p_phase;
        $past(reset_n) && !$past(demux_enable) |-> !clock_phase_select;
    endproperty
    a_phase: assert property (p_phase) else $error("phase select active without demux");
    property p_ipd;
        $past(reset_n) && $past(i_pd_pin) |-> i_power_down;
    endproperty
    a_ipd: assert property (p_ipd) else $error("power-down pin ignored");
    property p_short;
        both_input_short |-> dual_edge_mode && !interleave_input_sel;
    endproperty
    a_short: assert property (p_short) else $error("inputs shorted outside mode 101");
    property p_coarse;
        range_coarse == range_magnitude[14:6];
    endproperty
    a_coarse: assert property (p_coarse) else $error("coarse range not upper nine bits");
endmodule : ccr_link_asserts
`default_nettype wire

/* File: dv/converter_config_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module converter_config_regs_tb;
    import ccr_pkg::*;
    localparam int HALF = 2;
    logic        mclk, reset_n, wr, rd, ext, cal_pin, ipd_pin, qpd_pin, demux;
    logic [1:0]  addr;
    logic [15:0] wdata, rdata, pin_cfg;
    logic        cal_start, phs, swg, pat, ipd, qpd, lrs, des, isel, shrt, twos, stmp, osgn;
    logic [11:0] omag;
    logic [14:0] rmag;
    logic [8:0]  rcrs;
    logic [47:0] outs;
    logic [15:0] m [0:3];
    int          n_fail, cmp_count, seed, ncal;

    assign outs = {phs, swg, pat, ipd, qpd, lrs, des, isel, shrt, twos, stmp, osgn, omag, rmag, rcrs};
    ccr_link_if link();
    ccr_host #(.HALF_CYCLES(HALF)) ccr_host_i (.mclk(mclk), .reset_n(reset_n), .link(link),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    ccr_device ccr_device_i (.mclk(mclk), .reset_n(reset_n), .link(link),
        .extended_control_mode(ext), .cal_pin(cal_pin), .i_pd_pin(ipd_pin), .q_pd_pin(qpd_pin),
        .demux_enable(demux), .pin_config(pin_cfg), .cal_start(cal_start),
        .clock_phase_select(phs), .output_swing_high(swg), .fixed_pattern_mode(pat),
        .i_power_down(ipd), .q_power_down(qpd), .low_rate_select(lrs), .dual_edge_mode(des),
        .interleave_input_sel(isel), .both_input_short(shrt), .twos_comp_output(twos),
        .stamp_enable(stmp), .offset_sign(osgn), .offset_magnitude(omag),
        .range_magnitude(rmag), .range_coarse(rcrs));
    ccr_link_asserts #(.HALF_CYCLES(HALF)) ccr_link_asserts_i (.mclk(mclk), .reset_n(reset_n),
        .cs_n(link.cs_n), .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso),
        .demux_enable(demux), .i_pd_pin(ipd_pin), .cal_start(cal_start),
        .clock_phase_select(phs), .i_power_down(ipd), .dual_edge_mode(des),
        .interleave_input_sel(isel), .both_input_short(shrt), .range_magnitude(rmag),
        .range_coarse(rcrs));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Calibration starts seen so far
    always @(posedge mclk) if (cal_start === 1'b1) ncal++;

    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results
    // One-cycle command port strobes
    task automatic hw(input logic [1:0] a, input logic [15:0] dv);
        @(posedge mclk); addr <= a; wdata <= dv; wr <= 1'b1;
        @(posedge mclk); wr <= 1'b0;
    endtask : hw
    task automatic hr(input logic [1:0] a, output logic [15:0] dv);
        @(posedge mclk); addr <= a; rd <= 1'b1;
        @(posedge mclk); rd <= 1'b0;
        #1 dv = rdata;
    endtask : hr
    // One serial frame, busy polled under a bound
    task automatic xfer(input logic rw, input logic [3:0] a, input logic [15:0] dv,
                        output logic [15:0] rv);
        logic [15:0] st;
        st = 16'h0001;
        rv = 16'h0000;
        hw(CCR_H_TXDATA, dv);
        hw(CCR_H_CMD, {11'h000, rw, a});
        // A data write while the frame runs is refused; the staged word must survive it
        hw(CCR_H_TXDATA, ~dv);
        for (int i = 0; i < 400 && st[0] !== 1'b0; i++) hr(CCR_H_STATUS, st);
        check({47'h0, st[0]}, 48'h0);
        hr(CCR_H_TXDATA, st);
        check({32'h0, st}, {32'h0, dv});
        if (rw) hr(CCR_H_RXDATA, rv);
    endtask : xfer
    task automatic wreg(input logic [3:0] a, input logic [15:0] dv);
        logic [15:0] j;
        xfer(1'b0, a, dv, j);
        if (a < 4) m[a[1:0]] = dv;
    endtask : wreg
    task automatic rchk(input logic [3:0] a);
        logic [15:0] rv;
        xfer(1'b1, a, 16'h0000, rv);
        check({32'h0, rv}, {32'h0, (a < 4) ? m[a[1:0]] : CCR_ZERO});
    endtask : rchk
    // Expected decode of a config word and the two trims
    function automatic logic [47:0] expo(input logic [15:0] c, o, r);
        expo = {c[14] & demux, c[13], c[12], c[11] | ipd_pin, c[10] | qpd_pin, c[8], c[7],
                c[7] & c[6], c[7:5] == 3'h5, c[4], c[3], o[12], o[11:0], r[14:0], r[14:6]};
    endfunction : expo
    task automatic ochk();
        repeat (3) @(posedge mclk);
        #1;
        check(outs, ext ? expo(m[0], m[2], m[3]) : expo(pin_cfg, CCR_OFFSET_RST, CCR_RANGE_RST));
    endtask : ochk

    initial begin
        logic [3:0]  a;
        logic [15:0] d;
        int          base;
        seed = 7976; n_fail = 0; cmp_count = 0; ncal = 0;
        reset_n = 1'b0; addr = 2'h0; wdata = 16'h0000; wr = 1'b0; rd = 1'b0; ext = 1'b1;
        cal_pin = 1'b0; ipd_pin = 1'b0; qpd_pin = 1'b0; demux = 1'b1; pin_cfg = 16'h0000;
        m[0] = CCR_CONFIG_RST; m[1] = CCR_RSVD1_RST; m[2] = CCR_OFFSET_RST; m[3] = CCR_RANGE_RST;
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        // Power-on values, then two unmapped places
        for (int i = 0; i < 6; i++) rchk(i[3:0]);
        ochk();
        // Fixed mode words first so modes 101, 111 and 010 are set, then random traffic
        for (int i = 0; i < 14; i++) begin
            a = (i < 4) ? 4'h0 : 4'((({$random(seed)} % 4) * 3) & 4'hB);
            d = (i < 4) ? ((i == 0) ? 16'h40A0 : (i == 1) ? 16'hFDF8 : (i == 2) ? 16'h3C58 : 16'h00E0)
                        : 16'($random(seed));
            d = d & ((a == 4'h0) ? 16'hFDF8 : (a == 4'h2) ? 16'h1FFF
                   : (a == 4'h3) ? 16'h7FFF : 16'hFFFF);
            wreg(a, d);
            @(posedge mclk);
            demux <= 1'($random(seed)); ipd_pin <= 1'($random(seed)); qpd_pin <= 1'($random(seed));
            rchk(a);
            ochk();
        end
        // Calibration: start once, no retrigger while held, pin shares the request
        @(posedge mclk); ipd_pin <= 1'b0;
        wreg(4'h0, 16'h0000);
        base = ncal;
        wreg(4'h0, 16'h8000);
        ochk(); check(48'(ncal), 48'(base + 1));
        wreg(4'h0, 16'h8000);
        @(posedge mclk); cal_pin <= 1'b1;
        ochk(); check(48'(ncal), 48'(base + 1));
        @(posedge mclk); cal_pin <= 1'b0;
        wreg(4'h0, 16'h0000);
        @(posedge mclk); cal_pin <= 1'b1;
        ochk(); check(48'(ncal), 48'(base + 2));
        // Pin word takes over the config outside extended mode, trims use power-on values; stored words stay put
        @(posedge mclk); cal_pin <= 1'b0; ext <= 1'b0; pin_cfg <= 16'($random(seed));
        ochk();
        rchk(4'h3);
        @(posedge mclk); ext <= 1'b1;
        ochk();
        results();
    end
    // Hang guard
    initial begin
        repeat (40000) @(posedge mclk);
        n_fail++;
        results();
    end
endmodule : converter_config_regs_tb
`default_nettype wire
